//--- src/ebs_ctrl.sv
`timescale 1ns/1ps
module ebs_ctrl (
  input wire logic i_mclk,                  // 20 MHz system clock
  input wire logic i_sys_rst,               // sync reset, active high
  input wire logic i_req,                   // access request, level
  input wire logic i_req_wr,                // 1 write, 0 read
  input wire logic i_req_byte,              // 1 byte access, 0 word
  input wire logic [19:0] i_req_addr,       // access address
  input wire logic [15:0] i_req_wdata,      // write data
  input wire logic i_single_strobe_mode,    // 1 single strobe + enable
  input wire logic i_mux_bus8,              // 1 8-bit multiplexed bus
  input wire logic i_hold_req_n,            // bus release request
  input wire logic i_rdy_n,                 // ready low = wait
  input wire logic [15:0] i_data_in,        // data pins in
  output logic o_ack,                       // access done pulse
  output logic [15:0] o_rdata,              // read data
  output logic [19:0] o_addr,               // address pins
  output logic [15:0] o_data_out,           // data pins out
  output logic o_data_oe,                   // data pins driven
  output logic o_low_byte_store_strobe_n,   // also single store strobe
  output logic o_high_byte_store_strobe_n,  // also high byte enable
  output logic o_read_strobe_n,             // read strobe
  output logic o_addr_latch,                // address latch strobe
  output logic o_bus_release_grant_n,       // low while in hold
  output logic [3:0] o_chip_select_lines_n, // space selects
  output logic o_bclk                       // bus clock out
);
  typedef struct packed {
    ebs_pkg::ebs_state_e state;
    logic ack;
    logic [15:0] rdata;
    logic [19:0] addr;
    logic [15:0] dout;
    logic doe;
    logic wrl_n;
    logic wrh_n;
    logic rd_n;
    logic ale;
    logic grant_n;
    logic [3:0] cs_n;
    logic wr;
    logic byte_acc;
  } ebs_ctrl_s;

  ebs_ctrl_s st_reg;
  ebs_ctrl_s st_next;
  logic bclk_raw;
  logic tick;

  ebs_bclk_gen u_bclk (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .o_bclk(bclk_raw),
    .o_rise(tick)
  );

  logic [3:0] cs_dec;
  logic odd;
  logic lo_lane;
  logic hi_lane;
  always_comb begin
    cs_dec = ebs_pkg::CS_IDLE;
    cs_dec[st_reg.addr[ebs_pkg::CS_SEL_LSB +: ebs_pkg::CS_SEL_W]] = 1'b0;
    odd = st_reg.addr[0];
    lo_lane = !st_reg.byte_acc || !odd;
    hi_lane = !st_reg.byte_acc || odd;
  end

  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    if (tick) begin
      unique case (st_reg.state)
        ebs_pkg::ST_IDLE: begin
          if (!i_hold_req_n) begin
            st_next.state = ebs_pkg::ST_HOLD;
            st_next.grant_n = 1'b0;
          end else if (i_req) begin
            st_next.state = ebs_pkg::ST_ADDR;
            st_next.addr = i_req_addr;
            st_next.wr = i_req_wr;
            st_next.byte_acc = i_req_byte;
            st_next.ale = 1'b1;
            // multiplexed low byte carries address first
            st_next.dout = i_mux_bus8 ? {8'h00, i_req_addr[7:0]} :
                           i_req_wdata;
            st_next.doe = i_mux_bus8 | i_req_wr;
          end
        end
        ebs_pkg::ST_ADDR: begin
          st_next.ale = 1'b0;
          st_next.state = ebs_pkg::ST_STRB;
          st_next.cs_n = cs_dec;
          st_next.dout = i_req_wdata;
          st_next.doe = st_reg.wr;
          if (!st_reg.wr) begin
            st_next.rd_n = 1'b0;
          end else if (i_single_strobe_mode) begin
            st_next.wrl_n = 1'b0;
            st_next.wrh_n = !(hi_lane && odd) && st_reg.byte_acc;
          end else begin
            st_next.wrl_n = !lo_lane;
            st_next.wrh_n = !hi_lane;
          end
          if (!st_reg.wr && i_single_strobe_mode) begin
            st_next.wrh_n = !(hi_lane && odd) && st_reg.byte_acc;
          end
        end
        ebs_pkg::ST_STRB, ebs_pkg::ST_WAIT: begin
          // strobes, address and selects are left untouched here
          if (!i_rdy_n) begin
            st_next.state = ebs_pkg::ST_WAIT;
          end else begin
            st_next.state = ebs_pkg::ST_DONE;
            if (!st_reg.wr) begin
              st_next.rdata = i_data_in;
            end
            st_next.ack = 1'b1;
          end
        end
        ebs_pkg::ST_DONE: begin
          st_next.state = ebs_pkg::ST_IDLE;
          st_next.rd_n = 1'b1;
          st_next.wrl_n = 1'b1;
          st_next.wrh_n = 1'b1;
          st_next.cs_n = ebs_pkg::CS_IDLE;
          st_next.doe = 1'b0;
        end
        ebs_pkg::ST_HOLD: begin
          st_next.doe = 1'b0;
          if (i_hold_req_n) begin
            st_next.state = ebs_pkg::ST_IDLE;
            st_next.grant_n = 1'b1;
          end
        end
        default: begin
          st_next.state = ebs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_reg <= '{state: ebs_pkg::ST_IDLE, ack: 1'b0,
                  rdata: ebs_pkg::DATA_RST, addr: ebs_pkg::ADDR_RST,
                  dout: ebs_pkg::DATA_RST, doe: 1'b0, wrl_n: 1'b1,
                  wrh_n: 1'b1, rd_n: 1'b1, ale: 1'b0, grant_n: 1'b1,
                  cs_n: ebs_pkg::CS_IDLE, wr: 1'b0, byte_acc: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  logic bclk_reg;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      bclk_reg <= 1'b0;
    end else begin
      bclk_reg <= bclk_raw;
    end
  end

  assign o_ack = st_reg.ack;
  assign o_rdata = st_reg.rdata;
  assign o_addr = st_reg.addr;
  assign o_data_out = st_reg.dout;
  assign o_data_oe = st_reg.doe;
  assign o_low_byte_store_strobe_n = st_reg.wrl_n;
  assign o_high_byte_store_strobe_n = st_reg.wrh_n;
  assign o_read_strobe_n = st_reg.rd_n;
  assign o_addr_latch = st_reg.ale;
  assign o_bus_release_grant_n = st_reg.grant_n;
  assign o_chip_select_lines_n = st_reg.cs_n;
  assign o_bclk = bclk_reg;

  AST_GRANT_MATCH: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (st_reg.state == ebs_pkg::ST_HOLD) == !o_bus_release_grant_n)
    else $error("grant does not match hold state");
  AST_NO_CYCLE_IN_HOLD: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    !o_bus_release_grant_n |-> o_read_strobe_n && o_low_byte_store_strobe_n
      && o_high_byte_store_strobe_n && o_chip_select_lines_n == 4'hF)
    else $error("bus cycle while bus released");
  AST_WAIT_HOLDS: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (st_reg.state == ebs_pkg::ST_WAIT) |=> $stable(o_addr)
      && $stable(o_read_strobe_n) && $stable(o_low_byte_store_strobe_n)
      && $stable(o_high_byte_store_strobe_n)
      && $stable(o_chip_select_lines_n))
    else $error("bus cycle changed during wait");
  AST_RDY_WAIT: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    tick && st_reg.state == ebs_pkg::ST_STRB && !i_rdy_n
      |=> st_reg.state == ebs_pkg::ST_WAIT)
    else $error("ready low did not enter wait");
  AST_ALE_THEN_STROBE: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    $fell(o_addr_latch) |-> st_reg.state == ebs_pkg::ST_STRB)
    else $error("address latch not followed by strobe phase");
  AST_READ_STROBE: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    st_reg.state == ebs_pkg::ST_STRB && !st_reg.wr |-> !o_read_strobe_n)
    else $error("read strobe missing during read");
  AST_LANE_EVEN: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    st_reg.state == ebs_pkg::ST_STRB && st_reg.wr && st_reg.byte_acc
      && !st_reg.addr[0] && !i_single_strobe_mode
      |-> !o_low_byte_store_strobe_n && o_high_byte_store_strobe_n)
    else $error("wrong lane for even byte write");
  AST_ENABLE_ODD: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    st_reg.state == ebs_pkg::ST_STRB && st_reg.addr[0] && st_reg.wr
      && i_single_strobe_mode && $stable(i_single_strobe_mode)
      |-> !o_high_byte_store_strobe_n && !o_low_byte_store_strobe_n)
    else $error("high byte enable not low on odd access");
  AST_SELECT_SPACE: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    st_reg.state == ebs_pkg::ST_STRB
      |-> !o_chip_select_lines_n[o_addr[ebs_pkg::CS_SEL_LSB +:
        ebs_pkg::CS_SEL_W]] && $countones(o_chip_select_lines_n) == 3)
    else $error("chip select does not match address space");
endmodule

//--- src/ebs_pkg.sv
package ebs_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CS_N = 4;
  // chip select space decode: top two address bits pick one of four spaces
  localparam int CS_SEL_LSB = 18;
  localparam int CS_SEL_W = 2;
  // bus clock divider: bus clock toggles every BCLK_HALF system clocks
  localparam int BCLK_HALF = 1;
  localparam int ALE_CYC = 1;
  localparam int STROBE_CYC = 1;
  localparam logic [CS_N-1:0] CS_IDLE = 4'hF;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_STRB = 3'b011,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b110,
    ST_HOLD = 3'b100
  } ebs_state_e;
endpackage

//--- src/ebs_bclk_gen.sv
`timescale 1ns/1ps
module ebs_bclk_gen (
  input wire logic i_mclk,     // system clock
  input wire logic i_sys_rst,  // sync reset, active high
  output logic o_bclk,         // bus clock out
  output logic o_rise          // one-cycle pulse before bus clock rises
);
  typedef struct packed {
    logic bclk;
    logic rise;
  } ebs_bg_s;
  ebs_bg_s st_reg;
  ebs_bg_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.bclk = ~st_reg.bclk;
    st_next.rise = st_reg.bclk;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_bclk = st_reg.bclk;
  assign o_rise = st_reg.rise;
endmodule

//--- dv/ebs_mem_model.sv
`timescale 1ns/1ps
module ebs_mem_model (
  input wire logic i_mclk,         // system clock
  input wire logic i_single,       // 1 single strobe mode
  input wire logic i_lo_n,         // low or single store strobe
  input wire logic i_hi_n,         // high strobe or byte enable
  input wire logic i_rd_n,         // read strobe
  input wire logic [19:0] i_addr,  // address
  input wire logic [15:0] i_data,  // write data
  input wire logic [7:0] i_wait,   // cycles of ready low
  output logic [15:0] o_data,      // read data
  output logic o_rdy_n             // low = wait
);
  logic [15:0] mem [16];
  logic [7:0] cnt = 8'h00;
  logic [15:0] last = 16'h0000;
  logic wr_lo, wr_hi, act;
  assign wr_lo = i_single ? (!i_lo_n && !i_addr[0]) : !i_lo_n;
  assign wr_hi = i_single ? (!i_lo_n && !i_hi_n) : !i_hi_n;
  assign act = !(i_lo_n && i_hi_n && i_rd_n);
  assign o_rdy_n = !(act && cnt < i_wait);
  // a released bus must not look like the last read value
  assign o_data = i_rd_n ? ~last : mem[i_addr[4:1]];
  always @(posedge i_mclk) begin
    cnt <= act ? cnt + 8'h01 : 8'h00;
    if (!i_rd_n) last <= mem[i_addr[4:1]];
    if (wr_lo) mem[i_addr[4:1]][7:0] <= i_data[7:0];
    if (wr_hi) mem[i_addr[4:1]][15:8] <= i_data[15:8];
  end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_req = 1'b0, i_req_wr = 1'b0, i_req_byte = 1'b0;
  logic [19:0] i_req_addr = 20'h00000;
  logic [15:0] i_req_wdata = 16'h0000;
  logic i_single = 1'b0, i_mux8 = 1'b0, i_hold_n = 1'b1;
  logic [7:0] wait_n = 8'h00;
  logic ack, doe, lo_n, hi_n, rd_n, ale, grant_n, bclk, rdy_n, b0;
  logic [15:0] rdata, dout, din;
  logic [19:0] addr, s_adr;
  logic [3:0] cs_n, s_cs;
  logic [7:0] s_mux;
  logic s_lo, s_hi, s_rd, s_ale, s_oe;
  int fail_count = 0, checks = 0, lat, s_nlo;
  initial forever #25 i_mclk = ~i_mclk;
  ebs_ctrl dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_req(i_req),
    .i_req_wr(i_req_wr), .i_req_byte(i_req_byte), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .i_single_strobe_mode(i_single),
    .i_mux_bus8(i_mux8), .i_hold_req_n(i_hold_n), .i_rdy_n(rdy_n),
    .i_data_in(din), .o_ack(ack), .o_rdata(rdata), .o_addr(addr),
    .o_data_out(dout), .o_data_oe(doe), .o_low_byte_store_strobe_n(lo_n),
    .o_high_byte_store_strobe_n(hi_n), .o_read_strobe_n(rd_n),
    .o_addr_latch(ale), .o_bus_release_grant_n(grant_n),
    .o_chip_select_lines_n(cs_n), .o_bclk(bclk));
  ebs_mem_model mem (.i_mclk(i_mclk), .i_single(i_single), .i_lo_n(lo_n),
    .i_hi_n(hi_n), .i_rd_n(rd_n), .i_addr(addr), .i_data(dout),
    .i_wait(wait_n), .o_data(din), .o_rdy_n(rdy_n));
  task test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [19:0] e, input logic [19:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task clr;
    {s_lo, s_hi, s_rd, s_ale} = 4'h0;
    s_cs = 4'hF;
    s_nlo = 0;
    s_oe = 1'bx;
  endtask
  task watch;
    @(negedge i_mclk);
    if (ale === 1'b1) s_mux = dout[7:0];
    if (ale === 1'b1) s_ale = 1'b1;
    if (lo_n === 1'b0) s_nlo++;
    if (lo_n === 1'b0) s_lo = 1'b1;
    if (hi_n === 1'b0) s_hi = 1'b1;
    if (rd_n === 1'b0) s_rd = 1'b1;
    if (cs_n !== 4'hF) s_cs = cs_n;
    if (cs_n !== 4'hF) s_oe = doe;
    if (ale === 1'b1) s_adr = addr;
  endtask
  task run;
    for (lat = 0; lat < 100 && ack !== 1'b1; lat++) watch();
    if (ack !== 1'b1) begin
      fail_count++;
      test_done();
    end
    @(posedge i_mclk);
    i_req <= 1'b0;
  endtask
  task acc(input logic w, b, input logic [19:0] a, input logic [15:0] d);
    clr();
    @(posedge i_mclk);
    i_req <= 1'b1;
    i_req_wr <= w;
    i_req_byte <= b;
    i_req_addr <= a;
    i_req_wdata <= d;
    run();
  endtask
  task t_lanes;
    acc(1'b1, 1'b0, 20'h40004, 16'hA55A);
    chk("word lanes", 2'h3, {s_lo, s_hi});
    chk("select", 4'hD, s_cs);
    chk("addr latch", 1'h1, s_ale);
    chk("address", 20'h40004, s_adr);
    chk("write drive", 1'h1, s_oe);
    acc(1'b1, 1'b1, 20'h40005, 16'h3C3C);
    chk("odd lanes", 2'h1, {s_lo, s_hi});
    acc(1'b1, 1'b1, 20'h40006, 16'h0F0F);
    chk("even lanes", 2'h2, {s_lo, s_hi});
    acc(1'b0, 1'b0, 20'h40004, 16'h0000);
    chk("read data", 16'h3C5A, rdata);
    chk("read strobes", 3'h4, {s_rd, s_lo, s_hi});
    chk("read drive", 1'h0, s_oe);
    $display("test lanes done");
  endtask
  task t_single;
    i_single <= 1'b1;
    i_mux8 <= 1'b1;
    acc(1'b1, 1'b1, 20'hC0009, 16'h7171);
    chk("odd enable", 2'h3, {s_lo, s_hi});
    chk("mux addr", 8'h09, s_mux);
    chk("select", 4'h7, s_cs);
    acc(1'b1, 1'b1, 20'hC0008, 16'h2626);
    chk("even enable", 2'h2, {s_lo, s_hi});
    acc(1'b0, 1'b0, 20'hC0008, 16'h0000);
    chk("single read", 16'h7126, rdata);
    chk("read enable", 3'h5, {s_rd, s_lo, s_hi});
    chk("mux read drive", 1'h0, s_oe);
    i_single <= 1'b0;
    i_mux8 <= 1'b0;
    $display("test single done");
  endtask
  task t_wait;
    int l0;
    acc(1'b1, 1'b0, 20'h00002, 16'h1111);
    l0 = lat;
    wait_n <= 8'h06;
    acc(1'b1, 1'b0, 20'h00002, 16'h2222);
    chk("stretch", 1'h1, lat >= l0 + 4 && lat <= l0 + 8);
    chk("strobe held", 1'h1, s_nlo > 7);
    wait_n <= 8'h00;
    $display("test wait done");
  endtask
  task t_hold;
    @(posedge i_mclk);
    i_hold_n <= 1'b0;
    i_req <= 1'b1;
    i_req_wr <= 1'b0;
    i_req_addr <= 20'h40004;
    repeat (3) watch();
    clr();
    repeat (20) watch();
    chk("held off", 4'h0, {s_ale, s_rd, s_lo, s_hi});
    chk("grant", 1'h0, grant_n);
    @(posedge i_mclk);
    i_hold_n <= 1'b1;
    run();
    chk("read after hold", 16'h3C5A, rdata);
    chk("grant off", 1'h1, grant_n);
    $display("test hold done");
  endtask
  initial begin
    repeat (8) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    watch();
    watch();
    b0 = bclk;
    watch();
    chk("bus clock", 1'h1, bclk ^ b0);
    t_lanes();
    t_single();
    t_wait();
    t_hold();
    test_done();
  end
endmodule
